// [verilog/bir_regs.sv]
`timescale 1ns/1ps

// How it works
// - Bits 7..1 of register 0x0 hold the 7-bit bus address, loaded from the strap at start.
// - With the second-port enable set, port 1 answers at the port 0 address plus one.
// - Bit 0 of register 0x0 picks the strap address when 0 (default) and the field when 1.
// - Bit 3 of register 0x1 holds the receiver in reset while 1 and starts from the strap.
// - Writing 1 to bit 2 of register 0x1 pulses the receiver reset and the bit self-clears.
// - Writing 1 to bit 1 of register 0x1 resets all logic and registers, then self-clears.
// - Writing 1 to bit 0 of register 0x1 resets all logic but the registers, then clears.
// - That register-keeping reset reloads every strap-loaded field with its strapped value.
// - Bit 6 of register 0x2 swaps P and N of the port 1 clock lane.
// - Bit 5 of register 0x2 swaps P and N of all port 1 data lanes.
// - Bit 4 of register 0x2 reverses the port 1 lane order 3,2,1,0 to 0,1,2,3.
// - Bit 2 of register 0x2 swaps P and N of the port 0 clock lane.
// - Bit 1 of register 0x2 swaps P and N of all port 0 data lanes.
// - Bit 0 of register 0x2 reverses the port 0 lane order 3,2,1,0 to 0,1,2,3.
module bir_regs
	import bir_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire bir_req_t   req,
	output logic [7:0]      rdata,
	input  wire logic [6:0] address_strap_pin,
	input  wire logic       mode_strap_pin_b,
	input  wire logic       second_port_bus_enable,
	input  wire bir_lane_t  port0_lanes_in,
	input  wire bir_lane_t  port1_lanes_in,
	output bir_lane_t       port0_lanes_out,
	output bir_lane_t       port1_lanes_out,
	output logic [6:0]      port0_bus_address,
	output logic [6:0]      port1_bus_address,
	output logic            port1_address_valid,
	output logic            rx_reset,
	output logic            full_logic_reset,
	output logic            logic_reset_keep_regs
);

	// ==========================================================
	// Lane mapping
	function automatic bir_lane_t map_lanes(input bir_lane_t li, input logic clk_swap,
		input logic data_swap, input logic reverse);
		bir_lane_t o;
		o = li;
		if (reverse) begin
			o.data_p = {li.data_p[0], li.data_p[1], li.data_p[2], li.data_p[3]};
			o.data_n = {li.data_n[0], li.data_n[1], li.data_n[2], li.data_n[3]};
		end
		if (data_swap) begin
			o.data_p = reverse ? o.data_p : li.data_p;
			{o.data_p, o.data_n} = {o.data_n, o.data_p};
		end
		if (clk_swap) begin
			o.clk_p = li.clk_n;
			o.clk_n = li.clk_p;
		end
		return o;
	endfunction

	// ==========================================================
	// Synchronisers
	logic [6:0] addr_s1_q, addr_s2_q;
	logic       mode_s1_q, mode_s2_q;
	bir_lane_t  p0_s1_q, p0_s2_q, p1_s1_q, p1_s2_q;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			addr_s1_q <= '0;
			addr_s2_q <= '0;
			mode_s1_q <= 1'b0;
			mode_s2_q <= 1'b0;
			p0_s1_q   <= '0;
			p0_s2_q   <= '0;
			p1_s1_q   <= '0;
			p1_s2_q   <= '0;
		end else begin
			addr_s1_q <= address_strap_pin;
			addr_s2_q <= addr_s1_q;
			mode_s1_q <= mode_strap_pin_b;
			mode_s2_q <= mode_s1_q;
			p0_s1_q   <= port0_lanes_in;
			p0_s2_q   <= p0_s1_q;
			p1_s1_q   <= port1_lanes_in;
			p1_s2_q   <= p1_s1_q;
		end
	end

	// ==========================================================
	// Register state
	logic [6:0] addr_field_q;
	logic       addr_sel_q;
	logic       rx_hold_q, rx_pulse_q, full_q, keep_q;
	logic [7:0] lane_q;
	logic [1:0] strap_cnt_q;

	wire wr_addr    = req.wr && (req.addr == BIR_OFS_ADDR);
	wire wr_reset   = req.wr && (req.addr == BIR_OFS_RESET);
	wire wr_lane    = req.wr && (req.addr == BIR_OFS_LANE);
	wire load_strap = (strap_cnt_q == BIR_STRAP_LOAD);
	wire reload     = keep_q && !full_q;

	// Strap capture after reset release, restarted by the full reset
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			strap_cnt_q <= 2'h0;
		else if (full_q)
			strap_cnt_q <= 2'h0;
		else if (strap_cnt_q != BIR_STRAP_DONE)
			strap_cnt_q <= strap_cnt_q + 2'h1;
	end

	// Strap-loaded fields
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			addr_field_q <= '0;
			rx_hold_q    <= 1'b0;
		end else if (full_q) begin
			addr_field_q <= '0;
			rx_hold_q    <= 1'b0;
		end else if (load_strap || reload) begin
			addr_field_q <= addr_s2_q;
			rx_hold_q    <= mode_s2_q;
		end else begin
			if (wr_addr)
				addr_field_q <= req.wdata[7:1];
			if (wr_reset)
				rx_hold_q <= req.wdata[BIR_RX_HOLD_BIT];
		end
	end

	// Plain and self-clearing fields
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			addr_sel_q <= BIR_ADDR_SEL_RESET;
			lane_q     <= BIR_LANE_RESET;
			rx_pulse_q <= BIR_SELFCLR_RESET;
			full_q     <= BIR_SELFCLR_RESET;
			keep_q     <= BIR_SELFCLR_RESET;
		end else begin
			rx_pulse_q <= wr_reset && req.wdata[BIR_RX_PULSE_BIT];
			full_q     <= wr_reset && req.wdata[BIR_FULL_RST_BIT];
			keep_q     <= wr_reset && req.wdata[BIR_KEEP_RST_BIT];
			if (full_q) begin
				addr_sel_q <= BIR_ADDR_SEL_RESET;
				lane_q     <= BIR_LANE_RESET;
			end else begin
				if (wr_addr)
					addr_sel_q <= req.wdata[BIR_ADDR_SEL_BIT];
				if (wr_lane)
					lane_q <= req.wdata & BIR_LANE_MASK;
			end
		end
	end

	// ==========================================================
	// Outputs
	wire [6:0] base_addr = addr_sel_q ? addr_field_q : addr_s2_q;
	wire [7:0] rd_mux    = (req.addr == BIR_OFS_ADDR)  ? {addr_field_q, addr_sel_q} :
	                       (req.addr == BIR_OFS_RESET) ? {4'h0, rx_hold_q, rx_pulse_q,
	                                                      full_q, keep_q} :
	                       (req.addr == BIR_OFS_LANE)  ? lane_q : 8'h00;

	assign rx_reset              = rx_hold_q || rx_pulse_q;
	assign full_logic_reset      = full_q;
	assign logic_reset_keep_regs = keep_q;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rdata               <= 8'h00;
			port0_bus_address   <= '0;
			port1_bus_address   <= '0;
			port1_address_valid <= 1'b0;
			port0_lanes_out     <= '0;
			port1_lanes_out     <= '0;
		end else begin
			if (req.rd)
				rdata <= rd_mux;
			port0_bus_address   <= base_addr;
			port1_bus_address   <= base_addr + BIR_PORT1_STEP;
			port1_address_valid <= second_port_bus_enable;
			port0_lanes_out     <= map_lanes(p0_s2_q, lane_q[BIR_P0_CLK_BIT],
				lane_q[BIR_P0_DATA_BIT], lane_q[BIR_P0_REV_BIT]);
			port1_lanes_out     <= map_lanes(p1_s2_q, lane_q[BIR_P1_CLK_BIT],
				lane_q[BIR_P1_DATA_BIT], lane_q[BIR_P1_REV_BIT]);
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	sequence s_pulse_write(int b);
		wr_reset && req.wdata[b] ##1 !(wr_reset && req.wdata[b]);
	endsequence

	AST_STRAP_LOAD: assert property (load_strap && !full_q
		|=> addr_field_q == $past(addr_s2_q))
		else $error("address field not loaded from strap");
	AST_PORT1_ADDR: assert property (second_port_bus_enable
		|=> port1_address_valid && port1_bus_address == port0_bus_address + BIR_PORT1_STEP)
		else $error("port 1 address not base plus one");
	AST_PORT1_OFF: assert property (!second_port_bus_enable
		|=> !port1_address_valid)
		else $error("port 1 address valid while disabled");
	AST_ADDR_SRC: assert property (!addr_sel_q
		|=> port0_bus_address == $past(addr_s2_q))
		else $error("strap address not selected");
	AST_ADDR_PROG: assert property (addr_sel_q
		|=> port0_bus_address == $past(addr_field_q))
		else $error("programmed address not selected");
	AST_RX_HOLD: assert property (rx_hold_q
		&& !wr_reset && !full_q && !reload && !load_strap |=> rx_hold_q && rx_reset)
		else $error("receiver hold bit cleared by itself");
	AST_RX_PULSE: assert property (s_pulse_write(BIR_RX_PULSE_BIT)
		|-> rx_reset ##1 !rx_pulse_q)
		else $error("receiver reset pulse wrong");
	AST_FULL_RST: assert property (s_pulse_write(BIR_FULL_RST_BIT)
		|-> full_q ##1 (!full_q && lane_q == BIR_LANE_RESET && !addr_sel_q
		&& strap_cnt_q == 2'h0))
		else $error("full reset did not clear registers");
	AST_KEEP_RST: assert property (keep_q && !full_q && !wr_lane
		|=> lane_q == $past(lane_q) && addr_field_q == $past(addr_s2_q)
		&& rx_hold_q == $past(mode_s2_q))
		else $error("register keeping reset wrong");
	AST_KEEP_CLR: assert property (s_pulse_write(BIR_KEEP_RST_BIT)
		|-> ##1 !keep_q)
		else $error("self clearing bit did not clear");
	AST_P1_CLK: assert property (lane_q[BIR_P1_CLK_BIT]
		|=> port1_lanes_out.clk_p == $past(p1_s2_q.clk_n))
		else $error("port 1 clock swap wrong");
	AST_P1_DATA: assert property (lane_q[BIR_P1_DATA_BIT] && !lane_q[BIR_P1_REV_BIT]
		|=> port1_lanes_out.data_p == $past(p1_s2_q.data_n))
		else $error("port 1 data swap wrong");
	AST_P1_REV: assert property (lane_q[BIR_P1_REV_BIT] && !lane_q[BIR_P1_DATA_BIT]
		|=> port1_lanes_out.data_p[0] == $past(p1_s2_q.data_p[3]))
		else $error("port 1 lane reverse wrong");
	AST_P0_CLK: assert property (!lane_q[BIR_P0_CLK_BIT]
		|=> port0_lanes_out.clk_p == $past(p0_s2_q.clk_p))
		else $error("port 0 clock mapping wrong");
	AST_P0_DATA: assert property (lane_q[BIR_P0_DATA_BIT] && !lane_q[BIR_P0_REV_BIT]
		|=> port0_lanes_out.data_n == $past(p0_s2_q.data_p))
		else $error("port 0 data swap wrong");
	AST_P0_REV: assert property (lane_q[BIR_P0_REV_BIT] && !lane_q[BIR_P0_DATA_BIT]
		|=> port0_lanes_out.data_n[3] == $past(p0_s2_q.data_n[0]))
		else $error("port 0 lane reverse wrong");

endmodule

// [verilog/bir_pkg.sv]
package bir_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] BIR_OFS_ADDR  = 8'h00;
	localparam logic [7:0] BIR_OFS_RESET = 8'h01;
	localparam logic [7:0] BIR_OFS_LANE  = 8'h02;

	// ==========================================================
	// Field positions
	localparam int BIR_ADDR_SEL_BIT = 0;
	localparam int BIR_RX_HOLD_BIT  = 3;
	localparam int BIR_RX_PULSE_BIT = 2;
	localparam int BIR_FULL_RST_BIT = 1;
	localparam int BIR_KEEP_RST_BIT = 0;
	localparam int BIR_P1_CLK_BIT   = 6;
	localparam int BIR_P1_DATA_BIT  = 5;
	localparam int BIR_P1_REV_BIT   = 4;
	localparam int BIR_P0_CLK_BIT   = 2;
	localparam int BIR_P0_DATA_BIT  = 1;
	localparam int BIR_P0_REV_BIT   = 0;

	// ==========================================================
	// Reset values and constants
	localparam logic [7:0] BIR_LANE_RESET     = 8'h00;
	localparam logic [7:0] BIR_LANE_MASK      = 8'h77;
	localparam logic       BIR_ADDR_SEL_RESET = 1'b0;
	localparam logic       BIR_SELFCLR_RESET  = 1'b0;
	localparam logic [6:0] BIR_PORT1_STEP     = 7'h01;
	localparam logic [1:0] BIR_STRAP_LOAD     = 2'h2;
	localparam logic [1:0] BIR_STRAP_DONE     = 2'h3;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic       clk_p;
		logic       clk_n;
		logic [3:0] data_p;
		logic [3:0] data_n;
	} bir_lane_t;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} bir_req_t;

endpackage

// [dv/tb_top.sv]
`timescale 1ns/1ps
module tb_top
	import bir_pkg::*;
;
	logic            ref_clk;
	logic            resetn;
	bir_req_t        req;
	logic [7:0]      rdata;
	logic [6:0]      address_strap_pin;
	logic            mode_strap_pin_b;
	logic            second_port_bus_enable;
	bir_lane_t       port0_lanes_in;
	bir_lane_t       port1_lanes_in;
	bir_lane_t       port0_lanes_out;
	bir_lane_t       port1_lanes_out;
	logic [6:0]      port0_bus_address;
	logic [6:0]      port1_bus_address;
	logic            port1_address_valid;
	logic            rx_reset;
	logic            full_logic_reset;
	logic            logic_reset_keep_regs;
	int              miscompares;
	int              total_checks;
	int              seed;
	int              lane_m;
	logic [6:0]      a;
	int              mdl_q[$];
	bir_lane_t       exp_l;

	bir_regs u_dut (.ref_clk, .resetn, .req, .rdata, .address_strap_pin, .mode_strap_pin_b,
		.second_port_bus_enable, .port0_lanes_in, .port1_lanes_in, .port0_lanes_out,
		.port1_lanes_out, .port0_bus_address, .port1_bus_address, .port1_address_valid,
		.rx_reset, .full_logic_reset, .logic_reset_keep_regs);

	// ==========================================================
	// Clock, watchdog and helpers
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial begin
		#(25 * 5000);
		miscompares++;
		close_out();
	end
	task automatic close_out();
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic tally(input logic ok, input string what);
		total_checks++;
		if (!ok) begin
			miscompares++;
			$display("ERROR %0t %s mismatch", $time, what);
		end
	endtask
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		tally(got === exp, "register read");
	endtask
	task automatic chk_lane(input bir_lane_t got, input bir_lane_t exp);
		tally(got === exp, "lane mapping");
	endtask
	task automatic chk_addr(input logic [6:0] got, input logic [6:0] exp);
		tally(got === exp, "bus address");
	endtask
	task automatic chk_flag(input logic [1:0] got, input logic [1:0] exp);
		tally(got === exp, "reset output");
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// ==========================================================
	// Register model
	task automatic mdl_wr(input logic [7:0] ad, input logic [7:0] d);
		if (ad == BIR_OFS_ADDR) begin
			mdl_q[0] = d;
		end else if (ad == BIR_OFS_RESET) begin
			mdl_q[1] = d & 8'h08;
			if (d[1]) begin
				mdl_q[0] = {address_strap_pin, 1'b0};
				mdl_q[1] = {4'h0, mode_strap_pin_b, 3'h0};
				mdl_q[2] = 8'h00;
			end else if (d[0]) begin
				mdl_q[0] = {address_strap_pin, 1'b0} | (mdl_q[0] & 1);
				mdl_q[1] = {4'h0, mode_strap_pin_b, 3'h0};
			end
		end else if (ad == BIR_OFS_LANE) begin
			mdl_q[2] = d & 8'h77;
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(negedge ref_clk);
		req.addr = ad;
		req.wdata = d;
		req.wr = 1'b1;
		@(negedge ref_clk);
		req.wr = 1'b0;
		mdl_wr(ad, d);
	endtask
	task automatic rd(input logic [7:0] ad);
		@(negedge ref_clk);
		req.addr = ad;
		req.rd = 1'b1;
		@(negedge ref_clk);
		req.rd = 1'b0;
		chk_reg(rdata, (ad < 8'h03) ? 8'(mdl_q[ad]) : 8'h00);
	endtask
	function automatic bir_lane_t lmap(bir_lane_t i, logic c, logic d, logic r);
		bir_lane_t o;
		o = i;
		for (int k = 0; k < 4; k++) begin
			o.data_p[k] = r ? i.data_p[3-k] : i.data_p[k];
			o.data_n[k] = r ? i.data_n[3-k] : i.data_n[k];
		end
		if (c) begin
			o.clk_p = i.clk_n;
			o.clk_n = i.clk_p;
		end
		if (d) begin
			{o.data_p, o.data_n} = {o.data_n, o.data_p};
		end
		return o;
	endfunction

	// ==========================================================
	// Main sequence
	initial begin
		seed = 32'h5291;
		req = '0;
		resetn = 1'b0;
		address_strap_pin = 7'($random(seed));
		mode_strap_pin_b = 1'b1;
		second_port_bus_enable = 1'b0;
		port0_lanes_in = '0;
		port1_lanes_in = '0;
		mdl_q = '{0, 0, 0};
		mdl_q[0] = {address_strap_pin, 1'b0};
		mdl_q[1] = {4'h0, mode_strap_pin_b, 3'h0};
		mdl_q[2] = 8'h00;
		repeat (10) @(negedge ref_clk);
		resetn = 1'b1;
		cyc(4);
		rd(BIR_OFS_ADDR);
		rd(BIR_OFS_RESET);
		rd(BIR_OFS_LANE);
		chk_flag(rx_reset, mode_strap_pin_b);
		chk_addr(port0_bus_address, address_strap_pin);
		chk_flag(port1_address_valid, 1'b0);
		second_port_bus_enable = 1'b1;
		cyc(2);
		chk_flag(port1_address_valid, 1'b1);
		chk_addr(port1_bus_address, 7'(address_strap_pin + 7'h01));
		for (int i = 0; i < 2; i++) begin
			a = i ? 7'h7e : 7'($random(seed)) & 7'h7e;
			wr(BIR_OFS_ADDR, {a, 1'b1});
			cyc(2);
			rd(BIR_OFS_ADDR);
			chk_addr(port0_bus_address, a);
			chk_addr(port1_bus_address, 7'(a + 7'h01));
		end
		for (int i = 0; i < 8; i++) begin
			lane_m = $random(seed) & 8'hff;
			if (i < 3) begin
				lane_m = (i == 0) ? 8'hff : (i == 1) ? 8'h11 : 8'h22;
			end
			wr(BIR_OFS_LANE, 8'(lane_m));
			port0_lanes_in = 10'($random(seed));
			port1_lanes_in = 10'($random(seed));
			cyc(4);
			rd(BIR_OFS_LANE);
			exp_l = lmap(port0_lanes_in, lane_m[2], lane_m[1], lane_m[0]);
			chk_lane(port0_lanes_out, exp_l);
			exp_l = lmap(port1_lanes_in, lane_m[6], lane_m[5], lane_m[4]);
			chk_lane(port1_lanes_out, exp_l);
		end
		rd(8'h03);
		wr(8'h05, 8'hff);
		rd(BIR_OFS_LANE);
		wr(BIR_OFS_RESET, 8'h04);
		chk_flag(rx_reset, 1'b1);
		chk_flag({full_logic_reset, logic_reset_keep_regs}, 2'h0);
		cyc(1);
		chk_flag(rx_reset, 1'b0);
		rd(BIR_OFS_RESET);
		address_strap_pin = 7'($random(seed));
		cyc(3);
		wr(BIR_OFS_RESET, 8'h01);
		chk_flag({full_logic_reset, logic_reset_keep_regs}, 2'h1);
		cyc(1);
		chk_flag(logic_reset_keep_regs, 1'b0);
		rd(BIR_OFS_ADDR);
		rd(BIR_OFS_RESET);
		rd(BIR_OFS_LANE);
		chk_flag(rx_reset, 1'b1);
		chk_addr(port0_bus_address, address_strap_pin);
		mode_strap_pin_b = 1'b0;
		wr(BIR_OFS_RESET, 8'h00);
		chk_flag(rx_reset, 1'b0);
		wr(BIR_OFS_RESET, 8'h08);
		cyc(3);
		chk_flag(rx_reset, 1'b1);
		rd(BIR_OFS_RESET);
		wr(BIR_OFS_RESET, 8'h02);
		chk_flag({full_logic_reset, logic_reset_keep_regs}, 2'h2);
		cyc(1);
		chk_flag(full_logic_reset, 1'b0);
		cyc(4);
		rd(BIR_OFS_ADDR);
		rd(BIR_OFS_LANE);
		rd(BIR_OFS_RESET);
		chk_addr(port0_bus_address, address_strap_pin);
		second_port_bus_enable = 1'b0;
		cyc(2);
		chk_flag(port1_address_valid, 1'b0);
		chk_addr(port1_bus_address, 7'(address_strap_pin + 7'h01));
		close_out();
	end
endmodule
